// ### hdl/pitx_pkg.sv
// constants shared by the interrupt and transmit-mode register block
package pitx_pkg;

  // ----------------------------------------------------------------
  // control bus register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_INT_COND = 5'h02;
  localparam logic [4:0] ADDR_INT_MASK = 5'h03;
  localparam logic [4:0] ADDR_TX_STATE = 5'h04;
  localparam logic [4:0] ADDR_INT_CMP = 5'h1A;
  localparam logic [4:0] ADDR_TX_CMP = 5'h1B;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_COND_RST = 8'h10; // link threshold flag set
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [7:0] TX_STATE_RST = 8'hA2; // off mode, smoother, bit 7
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] LEM_COUNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_REQ_PAR_ERR = 0;
  localparam int BIT_CTL_PAR_ERR = 1;
  localparam int BIT_WR_REJECT = 2;
  localparam int BIT_WR_INHIBIT = 3;
  localparam int BIT_LINK_THRESH = 4;
  localparam int BIT_RCV_A = 5;
  localparam int BIT_RCV_B = 6;
  localparam int BIT_USER_SENSE = 7;
  localparam int TX_MODE_LSB = 0;
  localparam int INJ_LSB = 3;
  localparam int BIT_SMOOTHER = 5;
  localparam int BIT_REQ_PAR_CHK = 6;

  // ----------------------------------------------------------------
  // transmit modes, injection codes and line symbols
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_IDLE = 3'h1;
  localparam logic [2:0] MODE_OFF = 3'h2;
  localparam logic [2:0] MODE_MASTER = 3'h4;
  localparam logic [2:0] MODE_HALT = 3'h5;
  localparam logic [2:0] MODE_QUIET = 3'h6;
  localparam logic [1:0] INJ_ONE_SHOT = 2'h1;
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_HALT = 5'h04;
  localparam logic [4:0] SYM_QUIET = 5'h00;

  // addresses of read-only registers elsewhere in the device
  function automatic logic is_read_only(input logic [4:0] addr);
    case (addr)
      5'h08, 5'h0F, 5'h10, 5'h13, 5'h14: is_read_only = 1'b1;
      5'h16, 5'h18, 5'h19, 5'h1E, 5'h1F: is_read_only = 1'b1;
      default: is_read_only = 1'b0;
    endcase
  endfunction

endpackage

// ### hdl/pitx_core_if.sv
// signals between the register bank and its transmit and counter units
`timescale 1ns/1ps
interface pitx_core_if;
  logic [2:0] tx_mode;
  logic [9:0] req_pair;
  logic [9:0] filt_pair;
  logic filt_valid;
  logic [9:0] inj_pair;
  logic inj_valid;
  logic [9:0] tx_pair;
  logic tx_enable;
  logic lem_load;
  logic [7:0] lem_value;
  logic lem_error;
  logic lem_reached;

  modport ctrl (output tx_mode, req_pair, filt_pair, filt_valid, inj_pair,
    inj_valid, lem_load, lem_value, lem_error,
    input tx_pair, tx_enable, lem_reached);
  modport txgen (input tx_mode, req_pair, filt_pair, filt_valid, inj_pair,
    inj_valid, output tx_pair, tx_enable);
  modport lemc (input lem_load, lem_value, lem_error, output lem_reached);
endinterface

// ### hdl/pitx_lem_counter.sv
// link error monitor down-counter with a reached-zero pulse
`timescale 1ns/1ps
module pitx_lem_counter (
  input logic clk_sys,
  input logic srst,
  pitx_core_if.lemc core
);
  import pitx_pkg::*;

  logic [7:0] count_r;
  logic reached_r;

  wire count_zero = (count_r == 8'h00);
  wire count_last = (count_r == 8'h01);

  // ----------------------------------------------------------------
  // count down on each link error until zero, then hold; pulse when zero is reached
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_r <= LEM_COUNT_RST; // starts at zero
      reached_r <= 1'b0;
    end else if (core.lem_load) begin
      count_r <= core.lem_value;
      reached_r <= (core.lem_value == 8'h00);
    end else begin
      if (core.lem_error && !count_zero) count_r <= count_r - 8'h01;
      reached_r <= core.lem_error && count_last;
    end
  end

  assign core.lem_reached = reached_r;

  lem_pulse_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    core.lem_error && count_last && !core.lem_load |=> core.lem_reached)
    else $error("zero reach did not pulse");
endmodule // pitx_lem_counter

// ### hdl/pitx_tx_gen.sv
// transmit symbol pair selection with injection and mode priority
`timescale 1ns/1ps
module pitx_tx_gen (
  input logic clk_sys,
  input logic srst,
  pitx_core_if.txgen core
);
  import pitx_pkg::*;

  logic [9:0] pair_r;
  logic en_r;
  logic [9:0] mode_pair;

  // ----------------------------------------------------------------
  // symbols of the selected transmit mode; reserved codes give quiet
  // ----------------------------------------------------------------
  always_comb begin
    case (core.tx_mode)
      MODE_ACTIVE: mode_pair = core.filt_valid ? core.filt_pair
                                                : core.req_pair;
      MODE_IDLE: mode_pair = {SYM_IDLE, SYM_IDLE};
      MODE_MASTER: mode_pair = {SYM_HALT, SYM_QUIET};
      MODE_HALT: mode_pair = {SYM_HALT, SYM_HALT};
      MODE_OFF, MODE_QUIET: mode_pair = {SYM_QUIET, SYM_QUIET};
      default: mode_pair = {SYM_QUIET, SYM_QUIET};
    endcase
  end

  wire [9:0] out_nxt = core.inj_valid ? core.inj_pair : mode_pair;
  wire en_nxt = (core.tx_mode != MODE_OFF);

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pair_r <= {SYM_QUIET, SYM_QUIET};
      en_r <= 1'b0;
    end else begin
      pair_r <= out_nxt;
      en_r <= en_nxt;
    end
  end

  assign core.tx_pair = pair_r;
  assign core.tx_enable = en_r;

  off_mode_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    core.tx_mode == MODE_OFF && !core.inj_valid
    |=> !core.tx_enable && core.tx_pair == 10'h000)
    else $error("off mode not quiet or enable still high");
  inject_prio_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    core.inj_valid |=> core.tx_pair == $past(core.inj_pair))
    else $error("injected pair lost priority");
  idle_mode_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    core.tx_mode == MODE_IDLE && !core.inj_valid
    |=> core.tx_pair == 10'h3FF)
    else $error("idle mode pair wrong");
endmodule // pitx_tx_gen

// ### hdl/pitx_regs.sv
// interrupt condition, mask and transmit state registers on the control bus
`timescale 1ns/1ps
module pitx_regs (
  clk_sys, srst, cb_addr, cb_wdata, cb_wpar, cb_wr, cb_rd, cb_par_en,
  cb_rdata, cb_ack, int_n, req_pair, req_par, req_valid, filt_pair,
  filt_valid, inj_pair, inj_valid, oneshot_done, lem_load, lem_value,
  lem_error, receive_condition_a, receive_mask_a, receive_condition_b,
  receive_mask_b, sense_bits, tx_pair, optical_tx_enable, smoother_enable,
  request_parity_check_enable, injection_control
);
  import pitx_pkg::*;

  input logic clk_sys;
  input logic srst;
  input logic [4:0] cb_addr;
  input logic [7:0] cb_wdata;
  input logic cb_wpar;
  input logic cb_wr;
  input logic cb_rd;
  input logic cb_par_en;
  output logic [7:0] cb_rdata;
  output logic cb_ack;
  output logic int_n;
  input logic [9:0] req_pair;
  input logic req_par;
  input logic req_valid;
  input logic [9:0] filt_pair;
  input logic filt_valid;
  input logic [9:0] inj_pair;
  input logic inj_valid;
  input logic oneshot_done;
  input logic lem_load;
  input logic [7:0] lem_value;
  input logic lem_error;
  input logic [7:0] receive_condition_a;
  input logic [7:0] receive_mask_a;
  input logic [7:0] receive_condition_b;
  input logic [7:0] receive_mask_b;
  input logic [1:0] sense_bits;
  output logic [9:0] tx_pair;
  output logic optical_tx_enable;
  output logic smoother_enable;
  output logic request_parity_check_enable;
  output logic [1:0] injection_control;

  logic [7:0] int_cond_r;
  logic [7:0] int_cond_nxt;
  logic [7:0] int_mask_r;
  logic [7:0] tx_state_r;
  logic [7:0] tx_state_nxt;
  logic [7:0] int_cmp_r;
  logic [7:0] tx_cmp_r;
  logic [7:0] rdata_r;
  logic ack_r;
  logic int_n_r;

  pitx_core_if core ();

  // ----------------------------------------------------------------
  // control bus decode; a write with bad parity is dropped
  // ----------------------------------------------------------------
  wire ctl_par_err = cb_wr && cb_par_en && !(^{cb_wdata, cb_wpar});
  wire wr_ok = cb_wr && !ctl_par_err;
  wire wr_cond = wr_ok && (cb_addr == ADDR_INT_COND);
  wire wr_mask = wr_ok && (cb_addr == ADDR_INT_MASK);
  wire wr_txs = wr_ok && (cb_addr == ADDR_TX_STATE);
  wire wr_icmp = wr_ok && (cb_addr == ADDR_INT_CMP);
  wire wr_tcmp = wr_ok && (cb_addr == ADDR_TX_CMP);
  wire wr_reject = cb_wr && is_read_only(cb_addr);

  // ----------------------------------------------------------------
  // conditional write: only bits equal to the compare register move
  // ----------------------------------------------------------------
  wire [7:0] cond_eq = ~(int_cond_r ^ int_cmp_r);
  wire [7:0] txs_eq = ~(tx_state_r ^ tx_cmp_r);
  wire cond_inh = wr_cond && (int_cond_r != int_cmp_r);
  wire txs_inh = wr_txs && (tx_state_r != tx_cmp_r);
  wire [7:0] cond_sw = wr_cond ?
    ((int_cond_r & ~cond_eq) | (cb_wdata & cond_eq)) : int_cond_r;
  wire [7:0] txs_sw = wr_txs ?
    ((tx_state_r & ~txs_eq) | (cb_wdata & txs_eq)) : tx_state_r;

  // ----------------------------------------------------------------
  // hardware event sources of the condition flags
  // ----------------------------------------------------------------
  wire req_par_err = req_valid && tx_state_r[BIT_REQ_PAR_CHK]
    && !(^{req_pair, req_par});
  wire rcv_a_lvl = |(receive_condition_a & receive_mask_a);
  wire rcv_b_lvl = |(receive_condition_b & receive_mask_b);
  wire user_lvl = |sense_bits;
  wire [7:0] cond_set = {user_lvl, rcv_b_lvl, rcv_a_lvl, core.lem_reached,
    cond_inh | txs_inh, wr_reject, ctl_par_err, req_par_err};
  wire oneshot_clr = oneshot_done
    && (tx_state_r[INJ_LSB+:2] == INJ_ONE_SHOT);

  // ----------------------------------------------------------------
  // next values: a hardware set wins over a software clear
  // ----------------------------------------------------------------
  always_comb begin
    int_cond_nxt = cond_sw | cond_set;
    tx_state_nxt = txs_sw;
    if (oneshot_clr) tx_state_nxt[INJ_LSB] = 1'b0;
  end

  wire [7:0] rdata_nxt =
    (cb_addr == ADDR_INT_COND) ? int_cond_r :
    (cb_addr == ADDR_INT_MASK) ? int_mask_r :
    (cb_addr == ADDR_TX_STATE) ? tx_state_r :
    (cb_addr == ADDR_INT_CMP) ? int_cmp_r :
    (cb_addr == ADDR_TX_CMP) ? tx_cmp_r : 8'h00;

  // ----------------------------------------------------------------
  // condition and transmit state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_cond_r <= INT_COND_RST;
      tx_state_r <= TX_STATE_RST;
    end else begin
      int_cond_r <= int_cond_nxt;
      tx_state_r <= tx_state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // mask and compare registers, written without condition
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_mask_r <= INT_MASK_RST;
      int_cmp_r <= CMP_RST;
      tx_cmp_r <= CMP_RST;
    end else begin
      if (wr_mask) int_mask_r <= cb_wdata;
      if (wr_icmp) int_cmp_r <= cb_wdata;
      if (wr_tcmp) tx_cmp_r <= cb_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read data, access acknowledge and interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
      int_n_r <= 1'b1;
    end else begin
      if (cb_rd) rdata_r <= rdata_nxt;
      ack_r <= cb_rd | cb_wr;
      int_n_r <= ~|(int_cond_r & int_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // connections to the transmit and counter units
  // ----------------------------------------------------------------
  assign core.tx_mode = tx_state_r[TX_MODE_LSB+:3];
  assign core.req_pair = req_pair;
  assign core.filt_pair = filt_pair;
  assign core.filt_valid = filt_valid;
  assign core.inj_pair = inj_pair;
  assign core.inj_valid = inj_valid;
  assign core.lem_load = lem_load;
  assign core.lem_value = lem_value;
  assign core.lem_error = lem_error;

  pitx_tx_gen u_tx_gen (
    .clk_sys(clk_sys),
    .srst(srst),
    .core(core)
  );

  pitx_lem_counter u_lem_counter (
    .clk_sys(clk_sys),
    .srst(srst),
    .core(core)
  );

  // outputs, each straight from a flip-flop
  assign cb_rdata = rdata_r;
  assign cb_ack = ack_r;
  assign int_n = int_n_r;
  assign tx_pair = core.tx_pair;
  assign optical_tx_enable = core.tx_enable;
  assign smoother_enable = tx_state_r[BIT_SMOOTHER];
  assign request_parity_check_enable = tx_state_r[BIT_REQ_PAR_CHK];
  assign injection_control = tx_state_r[INJ_LSB+:2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mask_reset_a: assert property (@(posedge clk_sys)
    srst |=> int_mask_r == 8'h00)
    else $error("mask not cleared by reset");
  txs_reset_a: assert property (@(posedge clk_sys)
    srst |=> tx_state_r == 8'hA2 && optical_tx_enable == 1'b0 ##1 1'b1)
    else $error("transmit state reset value wrong");
  link_error_threshold_flag_reset_a: assert property (@(posedge clk_sys)
    srst |=> int_cond_r[4])
    else $error("link threshold flag not set by reset");
  link_error_threshold_flag_set_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    core.lem_reached |=> int_cond_r[4])
    else $error("link threshold flag missed");
  // the flag is sticky: only a software write may take it down
  link_error_threshold_flag_hold_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    int_cond_r[4] && !wr_cond |=> int_cond_r[4])
    else $error("link threshold flag dropped without a write");
  int_out_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    |(int_cond_r & int_mask_r) |=> !int_n)
    else $error("interrupt output not asserted");
  int_idle_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    !(|(int_cond_r & int_mask_r)) |=> int_n)
    else $error("interrupt output low with nothing enabled");
  rcv_set_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    |(receive_condition_a & receive_mask_a) |=> int_cond_r[5] ##1 1'b1)
    else $error("receive A flag not set");
  rcv_b_set_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    |(receive_condition_b & receive_mask_b) |=> int_cond_r[6])
    else $error("receive B flag not set");
  rcv_hold_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    $fell(int_cond_r[6])
    |-> $past(~|(receive_condition_b & receive_mask_b)))
    else $error("receive B flag cleared while pending");
  user_flag_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    $fell(int_cond_r[7]) |-> $past(sense_bits) == 2'b00)
    else $error("user flag cleared while a sense bit set");
  user_set_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    |sense_bits |=> int_cond_r[7])
    else $error("user flag not set");
  // bits that differed from the compare must hold; the one-shot clear
  // of injection bit 3 is left out
  inhibit_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    wr_ok && cb_addr == ADDR_TX_STATE && tx_state_r != tx_cmp_r
    |=> int_cond_r[3] && (((tx_state_r ^ $past(tx_state_r))
    & $past(tx_state_r ^ tx_cmp_r) & 8'hF7) == 8'h00))
    else $error("mismatched conditional write not inhibited");
  mask_rw_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    wr_mask |=> int_mask_r == $past(cb_wdata))
    else $error("mask write not stored");
  ack_pulse_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    cb_rd || cb_wr |=> cb_ack)
    else $error("access not acknowledged");
  // a software write may set the flag as well, so it is left out
  parity_en_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    $rose(int_cond_r[0]) && !$past(wr_cond) |-> $past(tx_state_r[6]))
    else $error("request parity flagged while disabled");
endmodule // pitx_regs

// ### tb/pitx_cpu_model.sv
// management processor model that drives the control bus of the block
`timescale 1ns/1ps
module pitx_cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] cb_rdata,
  input wire logic cb_ack,
  output logic [4:0] cb_addr,
  output logic [7:0] cb_wdata,
  output logic cb_wpar,
  output logic cb_wr,
  output logic cb_rd
);
  logic ack_seen;

  // bus idle from time zero
  initial begin
    cb_addr = 5'h00;
    cb_wdata = 8'h00;
    cb_wpar = 1'b1;
    cb_wr = 1'b0;
    cb_rd = 1'b0;
    ack_seen = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // one access: strobe raised after a falling edge, dropped a cycle later
  task automatic access(input logic [4:0] a, input logic [7:0] d,
    input logic wr, input logic bad, output logic [7:0] q);
    @(negedge clk_sys);
    cb_addr = a;
    cb_wdata = d;
    cb_wpar = (~^d) ^ bad; // odd parity unless spoiled on purpose
    cb_wr = wr;
    cb_rd = ~wr;
    @(negedge clk_sys);
    cb_wr = 1'b0;
    cb_rd = 1'b0;
    ack_seen = cb_ack;
    q = cb_rdata;
    cb_addr = ~a; // released address and data lines never keep the last value
    cb_wdata = ~d;
  endtask

  // write d through a compare loaded with the value just read back
  task automatic cond_write(input logic [4:0] a, input logic [4:0] cmp_a,
    input logic [7:0] d);
    logic [7:0] q;
    access(a, 8'h00, 1'b0, 1'b0, q);
    access(cmp_a, q, 1'b1, 1'b0, q);
    access(a, d, 1'b1, 1'b0, q);
  endtask
endmodule // pitx_cpu_model

// ### tb/phy_irq_and_tx_mode_regs_tb_top.sv
// self-checking bench for the interrupt and transmit-mode register block
`timescale 1ns/1ps
module phy_irq_and_tx_mode_regs_tb_top;
  import pitx_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cb_par_en = 1'b0;
  logic [9:0] req_pair = 10'h2B5;
  logic req_par = 1'b1;
  logic req_valid = 1'b1;
  logic [9:0] filt_pair = 10'h155;
  logic filt_valid = 1'b0;
  logic [9:0] inj_pair = 10'h0F3;
  logic inj_valid = 1'b0;
  logic oneshot_done = 1'b0;
  logic lem_load = 1'b0;
  logic [7:0] lem_value = 8'h02;
  logic lem_error = 1'b0;
  logic [7:0] receive_condition_a = 8'h04;
  logic [7:0] receive_mask_a = 8'h00;
  logic [7:0] receive_condition_b = 8'h00;
  logic [7:0] receive_mask_b = 8'hC0;
  logic [1:0] sense_bits = 2'b00;
  logic [4:0] cb_addr;
  logic [7:0] cb_wdata, cb_rdata;
  logic cb_wpar, cb_wr, cb_rd, cb_ack, int_n, optical_tx_enable;
  logic smoother_enable, request_parity_check_enable;
  logic [1:0] injection_control;
  logic [9:0] tx_pair;
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  pitx_regs i_dut (.clk_sys, .srst, .cb_addr, .cb_wdata, .cb_wpar, .cb_wr,
    .cb_rd, .cb_par_en, .cb_rdata, .cb_ack, .int_n, .req_pair, .req_par,
    .req_valid, .filt_pair, .filt_valid, .inj_pair, .inj_valid,
    .oneshot_done, .lem_load, .lem_value, .lem_error, .receive_condition_a,
    .receive_mask_a, .receive_condition_b, .receive_mask_b, .sense_bits,
    .tx_pair, .optical_tx_enable, .smoother_enable,
    .request_parity_check_enable, .injection_control);

  pitx_cpu_model i_cpu (.clk_sys, .cb_rdata, .cb_ack, .cb_addr, .cb_wdata,
    .cb_wpar, .cb_wr, .cb_rd);

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    i_cpu.access(a, 8'h00, 1'b0, 1'b0, q);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic b);
    logic [7:0] q;
    i_cpu.access(a, d, 1'b1, b, q);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] q;
    rd(ADDR_INT_COND, q);
    check(q, 8'h10);
    rd(ADDR_INT_MASK, q);
    check(q, 8'h00);
    rd(ADDR_TX_STATE, q);
    check(q, 8'hA2);
    check(int_n, 1'b1);
    check({optical_tx_enable, tx_pair}, 11'h000);
    check({smoother_enable, request_parity_check_enable,
      injection_control}, 4'h8);
    $display("test reset done");
  endtask

  task automatic t_mask();
    logic [7:0] q;
    wr(ADDR_INT_MASK, 8'h5A, 1'b0);
    rd(ADDR_INT_MASK, q);
    check(q, 8'h5A);
    check(i_cpu.ack_seen, 1'b1);
    wr(ADDR_INT_MASK, 8'hEF, 1'b0);
    wait_cyc(3);
    check(int_n, 1'b1);
    check(cb_ack, 1'b0);
    wr(ADDR_INT_MASK, 8'h10, 1'b0);
    wait_cyc(3);
    check(int_n, 1'b0);
    wr(ADDR_INT_MASK, 8'h00, 1'b0);
    $display("test mask done");
  endtask

  task automatic t_modes();
    logic [7:0] q;
    logic [9:0] e;
    for (int m = 0; m < 8; m++) begin
      i_cpu.cond_write(ADDR_TX_STATE, ADDR_TX_CMP, 8'hA0 | 8'(m));
      rd(ADDR_TX_STATE, q);
      check(q, 8'hA0 | 8'(m));
      case (m)
        1: e = {SYM_IDLE, SYM_IDLE};
        4: e = {SYM_HALT, SYM_QUIET};
        5: e = {SYM_HALT, SYM_HALT};
        0: e = req_pair;
        default: e = {SYM_QUIET, SYM_QUIET};
      endcase
      check(tx_pair, e);
      check(optical_tx_enable, m != 2);
    end
    $display("test modes done");
  endtask

  task automatic t_priority();
    i_cpu.cond_write(ADDR_TX_STATE, ADDR_TX_CMP, 8'hA0);
    filt_valid = 1'b1;
    wait_cyc(2);
    check(tx_pair, filt_pair);
    inj_valid = 1'b1;
    wait_cyc(2);
    check(tx_pair, inj_pair);
    inj_valid = 1'b0;
    i_cpu.cond_write(ADDR_TX_STATE, ADDR_TX_CMP, 8'hA1);
    wait_cyc(2);
    check(tx_pair, {SYM_IDLE, SYM_IDLE});
    filt_valid = 1'b0;
    $display("test priority done");
  endtask

  task automatic t_mismatch();
    logic [7:0] q;
    wr(ADDR_TX_CMP, 8'hA0, 1'b0);
    wr(ADDR_TX_STATE, 8'h00, 1'b0);
    rd(ADDR_TX_STATE, q);
    check(q, 8'h01);
    rd(ADDR_INT_COND, q);
    check(q, 8'h18);
    check(smoother_enable, 1'b0);
    $display("test conditional write done");
  endtask

  // drive source i full (2), partly (1, sense bits only; sources 0 and 1 drive full) or off (0)
  task automatic set_src(input int i, input int lv);
    @(negedge clk_sys);
    case (i)
      0: receive_mask_a = (lv != 0) ? 8'h04 : 8'h00;
      1: receive_condition_b = (lv != 0) ? 8'h40 : 8'h00;
      default: sense_bits = (lv == 2) ? 2'b11 : ((lv == 1) ? 2'b01 : 2'b00);
    endcase
    wait_cyc(3);
  endtask

  task automatic t_flags();
    logic [7:0] q;
    logic [7:0] e;
    i_cpu.cond_write(ADDR_INT_COND, ADDR_INT_CMP, 8'h00);
    rd(ADDR_INT_COND, q);
    check(q, 8'h00);
    for (int i = 0; i < 3; i++) begin
      e = 8'h20 << i;
      set_src(i, 2);
      rd(ADDR_INT_COND, q);
      check(q, e);
      set_src(i, 1);
      i_cpu.cond_write(ADDR_INT_COND, ADDR_INT_CMP, 8'h00);
      rd(ADDR_INT_COND, q);
      check(q, e);
      set_src(i, 0);
      i_cpu.cond_write(ADDR_INT_COND, ADDR_INT_CMP, 8'h00);
      rd(ADDR_INT_COND, q);
      check(q, 8'h00);
    end
    $display("test flags done");
  endtask

  task automatic t_lem();
    logic [7:0] q;
    lem_load = 1'b1;
    wait_cyc(1);
    lem_load = 1'b0;
    for (int n = 0; n < 2; n++) begin
      lem_error = 1'b1;
      wait_cyc(1);
      lem_error = 1'b0;
      wait_cyc(3);
      rd(ADDR_INT_COND, q);
      check(q, n == 1 ? 8'h10 : 8'h00);
    end
    rd(ADDR_INT_COND, q);
    check(q, 8'h10);
    $display("test link counter done");
  endtask

  task automatic t_parity();
    logic [7:0] q;
    i_cpu.cond_write(ADDR_INT_COND, ADDR_INT_CMP, 8'h00);
    req_par = ^req_pair;
    wait_cyc(2);
    req_par = ~^req_pair;
    rd(ADDR_INT_COND, q);
    check(q, 8'h00);
    i_cpu.cond_write(ADDR_TX_STATE, ADDR_TX_CMP, 8'h41);
    check(request_parity_check_enable, 1'b1);
    req_par = ^req_pair;
    wait_cyc(2);
    req_par = ~^req_pair;
    cb_par_en = 1'b1;
    wr(ADDR_INT_MASK, 8'h55, 1'b1);
    wr(5'h08, 8'h00, 1'b0);
    rd(ADDR_INT_MASK, q);
    check(q, 8'h00);
    rd(ADDR_INT_COND, q);
    check(q, 8'h07);
    $display("test parity and refusals done");
  endtask

  // one-shot completion takes injection bit 3 back down
  task automatic t_oneshot();
    i_cpu.cond_write(ADDR_TX_STATE, ADDR_TX_CMP, 8'h49);
    check(injection_control, 2'b01);
    oneshot_done = 1'b1;
    wait_cyc(1);
    oneshot_done = 1'b0;
    wait_cyc(1);
    check(injection_control, 2'b00);
    $display("test one-shot done");
  endtask

  // a hang ends the run as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    wait_cyc(6);
    srst = 1'b0;
    t_reset();
    t_mask();
    t_modes();
    t_priority();
    t_mismatch();
    t_flags();
    t_lem();
    t_parity();
    t_oneshot();
    print_verdict();
  end
endmodule // phy_irq_and_tx_mode_regs_tb_top
